// ===== hdl/adc_serial_port_pkg.sv
// Purpose: Shared constants and types for the converter serial port.
// Assumes: 40 MHz ref_clk_i, serial clock sampled as a plain input.
// Notes: Field positions follow the 13-bit input word and 32-bit output frame.
package adc_serial_port_pkg;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int FRAME_BITS = 32;
  localparam int RESULT_BITS = 24;
  localparam int SUB_BITS = 5;
  localparam int IN_WORD_BITS = 13;
  localparam logic [5:0] LAST_EDGE = 6'h20;
  localparam logic [5:0] APPLY_MIN_BITS = 6'h03;

  // Input word positions, counted as bits received (first bit is 0)
  localparam int POS_PRE_HI = 0;
  localparam int POS_PRE_LO = 1;
  localparam int POS_ACCEPT = 2;
  localparam int POS_SETUP = 8;

  // Default selection after reset: differential, ch0 positive, ch1 negative
  localparam logic [4:0] CHAN_RESET = 5'h00;
  localparam logic [1:0] REJECT_RESET = 2'h0;
  localparam logic TEMP_RESET = 1'b0;
  localparam logic DOUBLE_RESET = 1'b0;

  // Conversion length, in ref_clk_i cycles, standing in for the analog core
  localparam int CONV_TIME_US = 200;
  localparam int CLK_MHZ = 40;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;

  // Internal serial clock divider: half period in ref_clk_i cycles
  localparam logic [3:0] INT_SCK_HALF = 4'h4;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic single_ended_bit;
    logic swap_bit;
    logic channel_pick_2;
    logic channel_pick_1;
    logic channel_pick_0;
  } chan_sel_t;

  typedef struct packed {
    logic temperature_select;
    logic line_reject_hi;
    logic line_reject_lo;
    logic double_rate_bit;
  } setup_t;

  typedef struct packed {
    logic polarity_flag;
    logic [RESULT_BITS-1:0] code;
    logic [SUB_BITS-1:0] sub;
  } result_t;

  typedef enum logic [3:0] {
    ST_CONVERT = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_OUTPUT = 4'b0100,
    ST_WAIT = 4'b1000
  } port_state_t;

endpackage

// ===== hdl/result_formatter.sv
// Purpose: Builds the 30 low bits of the output frame from a signed sample.
// Assumes: Sample is a two's complement value scaled so +-2^28 is full scale,
//   with bit 5 worth one result step.
// Notes: Combinational; registered by the caller when a conversion ends.
module result_formatter
  import adc_serial_port_pkg::*;
(
  input wire logic signed [29:0] sample_i,
  output adc_serial_port_pkg::result_t result_o
);

  // ==========================================================================
  // Offset code with clamping
  // ==========================================================================
  // Limits sit where bit 28 would start to alias the polarity flag
  localparam logic signed [29:0] POS_LIMIT = 30'sh0fffffff;
  localparam logic signed [29:0] NEG_LIMIT = -30'sh10000000;

  // Range check first so clamping overrides the raw bits
  always_comb
  begin
    if (sample_i > POS_LIMIT)
    begin
      result_o = '{polarity_flag: 1'b1, code: 24'h800000, sub: 5'h00};
    end
    else if (sample_i < NEG_LIMIT)
    begin
      result_o = '{polarity_flag: 1'b0, code: 24'h7fffff, sub: 5'h1f};
    end
    else
    begin
      // Non-negative sets the flag; the 24 bits read as offset code
      result_o.polarity_flag = ~sample_i[29];
      result_o.code = sample_i[28:5];
      result_o.sub = sample_i[4:0];
    end
  end

endmodule

// ===== hdl/adc_serial_port.sv
// Purpose: Serial port of a delta-sigma converter: state control, result
//   frame out, configuration word in.
// Assumes: cs_n_i, sck_i and sdi_i are asynchronous pins; the analog core
//   is replaced by a sample input and a fixed conversion time.
// Notes: Both edges of the serial clock are found by oversampling, so the
//   link clock must stay well below a quarter of ref_clk_i.
//
// How it works
// - after conversion, sleep while select high; leave only on select low
// - when all 32 bits have been clocked out, start a new conversion
// - select rising during edges 1..32 aborts output and starts converting
// - input bits sampled on rising serial edges while select low in output
// - 32-bit frame: done flag, zero, polarity, 24 result, 5 sub bits
// - done bit high while converting, low when done; output floats if deselected
// - frame bit 30 is always driven low
// - bit 29 high for zero or positive input, low for negative
// - bits 29,28 both high is overrange; both low is underrange
// - bits 28..5 are the result MSB first, 4..0 are sub bits
// - with select high, output is high impedance and serial clock ignored
// - before clocking, output shows the live done flag for interrupt use
// - bit 31 read on first rise; later bits shift on falling edges
// - on the 32nd falling edge output goes high marking a new conversion
// - overrange clamps to +FS+1LSB, zero subs; underrange -FS-1LSB, one subs
// - polarity flag with 24 bits forms an offset binary code
// - accept a 13-bit word: channel group and setup group
// - reset selects ch0+/ch1-, both-line rejection, single rate
// - first conversion starts at reset; host writes after it completes
// - prefix 000 or 100 keeps previous channel and setup
// - prefix 101: next five bits choose channels and polarity
// - setup update bit 0 keeps the previous setup
// - update 1 loads temperature, two rejection bits, double rate (forced low with temperature)
// - serial clock internal when pin floats, external if held low at select fall
module adc_serial_port
  import adc_serial_port_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sck_pulled_i,
  input wire logic sdi_i,
  input wire logic signed [29:0] sample_i,
  output logic sck_o,
  output logic sck_oe_o,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic converting_o,
  output adc_serial_port_pkg::chan_sel_t chan_sel_o,
  output adc_serial_port_pkg::setup_t setup_o
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [1:0] cs_meta;
  logic [1:0] sck_meta;
  logic [1:0] sdi_meta;
  logic [1:0] pull_meta;
  logic cs_n;
  logic cs_n_d;
  logic sck_ext;
  logic sck_d;
  logic sdi_s;
  logic sck_low_s;

  // Two stages per pin; only the second stage feeds logic
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cs_meta <= 2'h3;
      sck_meta <= 2'h0;
      sdi_meta <= 2'h0;
      pull_meta <= 2'h0;
    end
    else
    begin
      cs_meta <= {cs_meta[0], cs_n_i};
      sck_meta <= {sck_meta[0], sck_i};
      sdi_meta <= {sdi_meta[0], sdi_i};
      pull_meta <= {pull_meta[0], sck_pulled_i};
    end
  end

  assign cs_n = cs_meta[1];
  assign sck_ext = sck_meta[1];
  assign sdi_s = sdi_meta[1];
  assign sck_low_s = pull_meta[1];

  // ==========================================================================
  // State and frame counters
  // ==========================================================================
  port_state_t state;
  logic [5:0] rise_cnt;
  logic [5:0] fall_cnt;
  logic [13:0] conv_cnt;
  logic ext_mode;
  logic int_phase;
  logic [3:0] div_cnt;
  logic sck_cur;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic frame_done;
  logic frame_abort;
  logic conv_end;
  logic start_conv;

  // Selected serial clock: pin in external mode, own divider otherwise
  assign sck_cur = ext_mode ? sck_ext : int_phase;
  assign cs_fall = cs_n_d && !cs_n;
  assign cs_rise = !cs_n_d && cs_n;
  assign sck_rise = (state == ST_OUTPUT) && !cs_n && !sck_d && sck_cur;
  assign sck_fall = (state == ST_OUTPUT) && !cs_n && sck_d && !sck_cur;
  assign frame_done = sck_fall && (fall_cnt == LAST_EDGE - 6'h01);
  assign frame_abort = cs_rise && (state == ST_OUTPUT) && (rise_cnt != 6'h00);
  assign conv_end = (state == ST_CONVERT) && (conv_cnt == 14'(CONV_CYCLES - 1));
  assign start_conv = frame_done || frame_abort;

  // Edge history of select and serial clock
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      cs_n_d <= cs_n;
      sck_d <= sck_cur;
    end
  end

  // Clock mode caught at each select fall; floating pin means internal
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_mode <= 1'b1;
    end
    else if (cs_fall)
    begin
      ext_mode <= sck_low_s;
    end
  end

  // Internal serial clock divider, runs only while shifting a frame
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || ext_mode || state != ST_OUTPUT || cs_n)
    begin
      div_cnt <= 4'h0;
      int_phase <= 1'b0;
    end
    else if (div_cnt == INT_SCK_HALF - 4'h1)
    begin
      div_cnt <= 4'h0;
      int_phase <= ~int_phase;
    end
    else
    begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // Main state sequence; reset starts the first conversion at once
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_CONVERT;
    end
    else
    begin
      unique case (state)
        ST_CONVERT:
        begin
          if (conv_end)
          begin
            state <= cs_n ? ST_SLEEP : ST_WAIT;
          end
        end
        ST_SLEEP:
        begin
          if (!cs_n)
          begin
            state <= ST_OUTPUT;
          end
        end
        ST_WAIT:
        begin
          // Done seen while selected; a fresh select fall opens the frame
          if (cs_n)
          begin
            state <= ST_SLEEP;
          end
        end
        ST_OUTPUT:
        begin
          if (start_conv)
          begin
            state <= ST_CONVERT;
          end
          else if (cs_n)
          begin
            state <= ST_SLEEP;
          end
        end
      endcase
    end
  end

  // Conversion timer stands in for the modulator
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || state != ST_CONVERT)
    begin
      conv_cnt <= 14'h0000;
    end
    else
    begin
      conv_cnt <= conv_cnt + 14'h0001;
    end
  end

  // Edge counters restart with every frame
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || state != ST_OUTPUT)
    begin
      rise_cnt <= 6'h00;
      fall_cnt <= 6'h00;
    end
    else
    begin
      if (sck_rise && rise_cnt != LAST_EDGE)
      begin
        rise_cnt <= rise_cnt + 6'h01;
      end
      if (sck_fall && fall_cnt != LAST_EDGE)
      begin
        fall_cnt <= fall_cnt + 6'h01;
      end
    end
  end

  // ==========================================================================
  // Result capture and output shifter
  // ==========================================================================
  result_t fmt;
  result_t held;
  logic [FRAME_BITS-1:0] shift;

  result_formatter u_fmt (
    .sample_i(sample_i),
    .result_o(fmt)
  );

  // Result frozen at the end of each conversion
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      held <= '0;
    end
    else if (conv_end)
    begin
      held <= fmt;
    end
  end

  // Frame loaded on entry to output, shifted on each falling edge
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      shift <= '0;
    end
    else if (state != ST_OUTPUT)
    begin
      shift <= {1'b0, 1'b0, held};
    end
    else if (sck_fall)
    begin
      shift <= {shift[FRAME_BITS-2:0], 1'b1};
    end
  end

  // Output pin: live done flag, frame bits, high after the last fall
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else
    begin
      sdo_oe_o <= !cs_n;
      if (state == ST_CONVERT)
      begin
        sdo_o <= 1'b1;
      end
      else if (state != ST_OUTPUT || fall_cnt == 6'h00)
      begin
        sdo_o <= 1'b0;
      end
      else
      begin
        sdo_o <= shift[FRAME_BITS-1];
      end
    end
  end

  // Internal clock drive only in internal mode while selected
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      converting_o <= 1'b1;
    end
    else
    begin
      sck_o <= int_phase;
      sck_oe_o <= !ext_mode && !cs_n;
      converting_o <= (state == ST_CONVERT);
    end
  end

  // ==========================================================================
  // Configuration word capture
  // ==========================================================================
  logic [IN_WORD_BITS-1:0] in_word;

  // Bits taken on rising edges, first bit ends in the top position
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || state != ST_OUTPUT)
    begin
      in_word <= '0;
    end
    else if (sck_rise && rise_cnt < 6'(IN_WORD_BITS))
    begin
      in_word[IN_WORD_BITS-1-rise_cnt[3:0]] <= sdi_s;
    end
  end

  // Applied when a frame ends or aborts; channel needs 9 bits in, setup all 13
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      chan_sel_o <= CHAN_RESET;
      setup_o <= {TEMP_RESET, REJECT_RESET, DOUBLE_RESET};
    end
    else if (start_conv && rise_cnt >= 6'(POS_SETUP + 1)
             && in_word[IN_WORD_BITS-1-POS_PRE_HI] && !in_word[IN_WORD_BITS-1-POS_PRE_LO]
             && in_word[IN_WORD_BITS-1-POS_ACCEPT])
    begin
      chan_sel_o <= in_word[9:5];
      if (in_word[IN_WORD_BITS-1-POS_SETUP] && rise_cnt >= 6'(IN_WORD_BITS))
      begin
        setup_o.temperature_select <= in_word[3];
        setup_o.line_reject_hi <= in_word[2];
        setup_o.line_reject_lo <= in_word[1];
        // Temperature runs force single rate
        setup_o.double_rate_bit <= in_word[0] & ~in_word[3];
      end
    end
  end

endmodule

// ===== bench/adc_port_assertions.sv
// Purpose: Port level checks on the converter serial port.
// Assumes: Pins reach the core through two-flop synchronisers.
// Notes: Short repeats cover the sync and register delay.
module adc_port_checker
  import adc_serial_port_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_oe_o,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic converting_o,
  input wire adc_serial_port_pkg::chan_sel_t chan_sel_o,
  input wire adc_serial_port_pkg::setup_t setup_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_serial_port_pkg::*;
  localparam int CONV_MIN = CONV_CYCLES - 8;
  localparam int CONV_MAX = CONV_CYCLES + 8;
  int conv_len;

  // ==========================================================================
  // Helper
  // ==========================================================================
  // Counter keeps the long conversion bound out of a repeat
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !converting_o)
      conv_len <= 0;
    else
      conv_len <= conv_len + 1;
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_float_deselected: assert property (cs_n_i [*4] |-> !sdo_oe_o)
    else $error("sdo driven while deselected");
  chk_drive_selected: assert property ((!cs_n_i) [*5] |-> sdo_oe_o)
    else $error("sdo not driven while selected");
  chk_busy_flag_high: assert property ((!cs_n_i && converting_o && sdo_oe_o) [*2] |-> sdo_o)
    else $error("busy flag low during conversion");
  chk_done_flag_low: assert property ($fell(converting_o) && !cs_n_i && sdo_oe_o |-> ##[0:2] !sdo_o)
    else $error("done flag did not fall");
  chk_sleep_stays: assert property ((cs_n_i && !converting_o) [*8] |=> !converting_o)
    else $error("left sleep without select");
  chk_chan_at_start: assert property ($changed(chan_sel_o) |=> $rose(converting_o))
    else $error("channel changed outside conversion start");
  chk_setup_at_start: assert property ($changed(setup_o) |=> $rose(converting_o))
    else $error("setup changed outside conversion start");
  chk_conv_length: assert property ($fell(converting_o) |-> conv_len >= CONV_MIN && conv_len <= CONV_MAX)
    else $error("conversion length wrong");
  chk_sck_released: assert property (cs_n_i [*4] |-> !sck_oe_o)
    else $error("serial clock driven while deselected");
endmodule

bind adc_serial_port adc_port_checker chk_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .sck_oe_o(sck_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .converting_o(converting_o),
  .chan_sel_o(chan_sel_o), .setup_o(setup_o));

// ===== bench/spi_host_model.sv
// Purpose: Host side of the serial link, as a master with its own clock.
// Assumes: External clock mode, 200 ns period, 7 ns off the core clock.
// Notes: Data changes on falling clock, read on rising clock.
module spi_host_model (
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, clock held low for external mode
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end

  // Select or deselect only; data line parked low at select
  task automatic select(input logic v);
    #7 cs_n_o = v;
    sdi_o = 1'b0;
  endtask

  // One transfer of a given number of rising edges
  task automatic xfer(input logic [12:0] word, input int rises, output logic [31:0] rx, output logic tail);
    rx = '0;
    #7 cs_n_o = 1'b0;
    #300;
    for (int i = 0; i < rises; i++)
    begin
      sdi_o = (i < 13) ? word[12 - i] : ~sdi_o;
      #100 sck_o = 1'b1;
      rx = {rx[30:0], sdo_i};
      #100 sck_o = 1'b0;
    end
    #300 tail = sdo_i;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
endmodule

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the converter serial port.
// Assumes: Host model owns select and data in, and the clock except in internal mode.
// Notes: Results judged only on codes that do not depend on scale.
module testbench
  import adc_serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_n_i, sck_pulled_i, cs_n, host_sck, sck_w, sdi;
  logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, converting_o, tail, sdo_w;
  logic signed [29:0] sample_i;
  logic [31:0] rx;
  chan_sel_t chan_sel_o;
  setup_t setup_o;
  int fail_count, total_checks, cycles;

  // Shared clock wire: core drives it in internal mode
  assign sck_w = sck_oe_o ? sck_o : host_sck;
  // Released data line shows the inverse so a late read cannot pass
  assign sdo_w = sdo_oe_o ? sdo_o : ~sdo_o;

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  adc_serial_port dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck_w),
    .sck_pulled_i(sck_pulled_i), .sdi_i(sdi), .sample_i(sample_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .converting_o(converting_o), .chan_sel_o(chan_sel_o),
    .setup_o(setup_o));
  spi_host_model host_u (.cs_n_o(cs_n), .sck_o(host_sck), .sdi_o(sdi), .sdo_i(sdo_w));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Bounded wait so a stuck conversion cannot hang the run
  task automatic wait_idle(output int n);
    n = 0;
    while (converting_o !== 1'b0 && n < 9000)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    check(n < 9000, "idle wait");
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_power_up();
    int n;
    check(converting_o === 1'b1, "not converting");
    check(chan_sel_o === CHAN_RESET && setup_o === {TEMP_RESET, REJECT_RESET, DOUBLE_RESET}, "defaults");
    host_u.select(1'b0);
    repeat (8) @(posedge ref_clk_i);
    check(sdo_oe_o === 1'b1 && sdo_o === 1'b1, "busy flag");
    wait_idle(n);
    check(n > CONV_CYCLES - 20 && n < CONV_CYCLES + 5, "conversion time");
    repeat (3) @(posedge ref_clk_i);
    check(sdo_o === 1'b0, "done flag");
    host_u.select(1'b1);
    repeat (8) @(posedge ref_clk_i);
    check(sdo_oe_o === 1'b0, "sdo kept");
    repeat (100) @(posedge ref_clk_i);
    check(converting_o === 1'b0, "left sleep");
    $display("end t_power_up");
  endtask

  task automatic t_write_full();
    host_u.xfer(13'b1011100110011, 32, rx, tail);
    @(posedge ref_clk_i);
    sample_i <= 30'h1fffffff;
    repeat (8) @(posedge ref_clk_i);
    check(rx[31:5] === 27'h1000000, "zero code");
    check(tail === 1'b1 && converting_o === 1'b1, "no restart");
    check(chan_sel_o === 5'b11001 && setup_o === 4'b0011, "selection");
    $display("end t_write_full");
  endtask

  task automatic t_keep_prefix();
    int n;
    wait_idle(n);
    host_u.xfer(13'b1000011011100, 32, rx, tail);
    @(posedge ref_clk_i);
    sample_i <= 30'h20000000;
    repeat (8) @(posedge ref_clk_i);
    check(rx === 32'h30000000, "overrange code");
    check(chan_sel_o === 5'b11001 && setup_o === 4'b0011, "kept");
    $display("end t_keep_prefix");
  endtask

  task automatic t_update_off();
    int n;
    wait_idle(n);
    host_u.xfer(13'b1010011001100, 32, rx, tail);
    @(posedge ref_clk_i);
    sample_i <= '0;
    repeat (8) @(posedge ref_clk_i);
    check(rx === 32'h0fffffff, "underrange code");
    check(chan_sel_o === 5'b00110 && setup_o === 4'b0011, "setup kept");
    $display("end t_update_off");
  endtask

  int n_list[2] = '{1, 12};

  task automatic t_abort();
    int n;
    foreach (n_list[k])
    begin
      wait_idle(n);
      host_u.xfer(13'b0000011011100, n_list[k], rx, tail);
      repeat (8) @(posedge ref_clk_i);
      check(converting_o === 1'b1, "abort");
      check(chan_sel_o === 5'b00110, "abort kept");
    end
    $display("end t_abort");
  endtask

  // Abort once the whole word is in: channel and setup land together
  task automatic t_abort_apply();
    int n;
    wait_idle(n);
    host_u.xfer(13'h143d, IN_WORD_BITS, rx, tail);
    repeat (8) @(posedge ref_clk_i);
    check(converting_o === 1'b1, "late abort");
    check(chan_sel_o === 5'h01 && setup_o === 4'hc, "late abort applied");
    $display("end t_abort_apply");
  endtask

  task automatic t_internal();
    int n;
    int edges;
    logic prev;
    wait_idle(n);
    sck_pulled_i <= 1'b0;
    @(posedge ref_clk_i);
    host_u.select(1'b0);
    repeat (8) @(posedge ref_clk_i);
    check(sck_oe_o === 1'b1, "internal clock");
    n = 0;
    edges = 0;
    prev = sck_o;
    // Count rises of the driven clock until the frame restarts conversion
    while (converting_o !== 1'b1 && n < 600)
    begin
      @(posedge ref_clk_i);
      n++;
      if (sck_o === 1'b1 && prev === 1'b0)
      begin
        edges++;
      end
      prev = sck_o;
    end
    check(n < 600, "internal frame");
    check(edges == FRAME_BITS, "internal clock edges");
    host_u.select(1'b1);
    repeat (8) @(posedge ref_clk_i);
    check(sck_oe_o === 1'b0, "clock kept");
    sck_pulled_i <= 1'b1;
    $display("end t_internal");
  endtask

  // ==========================================================================
  // Main sequence and timeout
  // ==========================================================================
  initial
  begin
    rst_n_i = 1'b0;
    sample_i = '0;
    sck_pulled_i = 1'b1;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_power_up();
    t_write_full();
    t_keep_prefix();
    t_update_off();
    t_abort();
    t_abort_apply();
    t_internal();
    stop_test();
  end

  // Ceiling well above eight conversions of 8000 cycles
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end
endmodule
